// ===== core/dadio_top.v
// data alu operand sequencer: denormal handling, nan treatment, sticky
// exception flags and integer operations on the low register portions
// assumes the controller holds operands only on the issue cycle and that the
// floating point units answer combinationally while FP_GO is high
//
// Function
// - a status word bit picks flush-to-zero or full ieee denormal handling
// - flush mode treats denormal operands as zero, source registers left alone
// - flush mode writes zero for any result that would be denormal
// - flush mode adds no cycles for denormal values
// - ieee mode adds one entry cycle when any input operand is denormal
// - ieee mode then adds one cycle per denormal operand, source unchanged
// - all chip activity stalls while input operands are normalized
// - in ieee mode each denormal result costs one extra cycle, with no entry cycle
// - adder operations on single extended denormals take no extra cycles
// - integer sizes are byte, short word, word and long word
// - word integers fit either data space, long integers only long space
// - long integers may be results but never direct input operands
// - integer operations read and write the low register portions
// - integer add and subtract give a 32-bit low-portion result
// - integer multiply, signed or unsigned, writes a 64-bit low/middle product
// - logic unit does and, and-complement, or, or-complement, xor, not, rotate
// - logic unit does field divide, merge and extract, word and byte
// - barrel shifter does arithmetic and logical shifts, left and right
// - quiet nan operands give a quiet nan and raise no exception
// - signaling nan operands raise invalid and give a quiet nan
// - float operands are single or register sized; double operands are refused
// - five exceptions detected: invalid, divide by zero, overflow, underflow, inexact
// - exceptions set sticky flags until software clears them
// - only the all-ones fraction quiet nan is ever produced
`timescale 1ns/100ps
`include "dadio_map.vh"

module dadio_top (
    input  wire        CLOCK,
    input  wire        NRST,
    input  wire        CE,
    input  wire        FLUSH_ZERO_SELECT,
    input  wire        ISSUE,
    input  wire [4:0]  OPCODE,
    input  wire [1:0]  SIZE,
    input  wire [1:0]  FLOAT_SIZE,
    input  wire        SINGLE_EXTENDED_FORMAT,
    input  wire [31:0] OPA,
    input  wire [31:0] OPB,
    input  wire [31:0] FP_RESULT,
    input  wire [4:0]  FP_EXC,
    input  wire [4:0]  FLAG_CLEAR,
    output wire        STALL,
    output wire        BUSY,
    output wire        DONE,
    output wire        LONG_REJECT,
    output wire [31:0] RESULT_LOW,
    output wire [31:0] RESULT_MID,
    output wire        RESULT_LONG,
    output wire [4:0]  FLAGS,
    output wire        FP_GO,
    output wire        FP_MUL,
    output wire        OPA_SIGN,
    output wire [9:0]  OPA_EXP,
    output wire [23:0] OPA_MANT,
    output wire        OPB_SIGN,
    output wire [9:0]  OPB_EXP,
    output wire [23:0] OPB_MANT
);
    localparam [5:0] ST_IDLE    = 6'h01;
    localparam [5:0] ST_ENTRY   = 6'h02;
    localparam [5:0] ST_NORM_A  = 6'h04;
    localparam [5:0] ST_NORM_B  = 6'h08;
    localparam [5:0] ST_EXEC    = 6'h10;
    localparam [5:0] ST_OUTNORM = 6'h20;
    localparam [1:0] FSZ_DOUBLE = 2'h1;

    reg  [5:0]  state_r;
    reg  [5:0]  state_nxt;
    reg         stall_r;
    reg         busy_r;
    reg         done_r;
    reg         long_rej_r;
    reg  [31:0] res_low_r;
    reg  [31:0] res_mid_r;
    reg         res_long_r;
    reg  [4:0]  flags_r;
    reg  [4:0]  flag_set;
    reg         fp_go_r;
    reg         fp_mul_r;
    reg         fz_r;
    reg         nan_r;
    reg         snan_r;
    reg         pend_a_r;
    reg         pend_b_r;
    reg  [31:0] opa_r;
    reg  [31:0] opb_r;
    reg  [9:0]  a_exp_r;
    reg  [23:0] a_mant_r;
    reg  [9:0]  b_exp_r;
    reg  [23:0] b_mant_r;
    reg  [31:0] fin_res;

    wire [31:0] int_lo;
    wire [31:0] int_mid;
    wire        int_long;

    // operand classes, single precision encoding
    function is_den;
        input [31:0] x;
        begin
            is_den = (x[`DADIO_SP_EXP_MSB:`DADIO_SP_EXP_LSB] == `DADIO_SP_EXP_ZERO) &&
                     (x[`DADIO_SP_FRAC_MSB:0] != 23'h000000);
        end
    endfunction

    function is_nan;
        input [31:0] x;
        begin
            is_nan = (x[`DADIO_SP_EXP_MSB:`DADIO_SP_EXP_LSB] == `DADIO_SP_EXP_MAX) &&
                     (x[`DADIO_SP_FRAC_MSB:0] != 23'h000000);
        end
    endfunction

    // internal form: biased exponent (two's complement, may go below one)
    // and a mantissa with the hidden bit at the top
    function [33:0] norm_op;
        input [31:0] x;
        input        flush;
        integer      i;
        reg   [4:0]  lz;
        reg          found;
        reg   [23:0] m;
        begin
            lz    = 5'h00;
            found = 1'b0;
            for (i = 22; i >= 0; i = i - 1) begin
                if (!found) begin
                    if (x[i])
                        found = 1'b1;
                    else
                        lz = lz + 5'h01;
                end
            end
            m = {x[`DADIO_SP_FRAC_MSB:0], 1'b0} << lz;
            if (x[`DADIO_SP_EXP_MSB:`DADIO_SP_EXP_LSB] != `DADIO_SP_EXP_ZERO)
                norm_op = {2'h0, x[`DADIO_SP_EXP_MSB:`DADIO_SP_EXP_LSB],
                           1'b1, x[`DADIO_SP_FRAC_MSB:0]};
            else if (flush || !found)
                norm_op = {10'h000, 24'h000000};
            else
                norm_op = {10'h000 - {5'h00, lz}, m};
        end
    endfunction

    wire        is_float  = (OPCODE == `DADIO_OP_FLOAT_ADD) ||
                            (OPCODE == `DADIO_OP_FLOAT_MUL);
    wire        den_a     = is_den(OPA);
    wire        den_b     = is_den(OPB);
    // single extended operands in the adder are aligned by the adder itself
    wire        sep_add   = SINGLE_EXTENDED_FORMAT &&
                            (OPCODE == `DADIO_OP_FLOAT_ADD);
    wire        ieee_seq  = !FLUSH_ZERO_SELECT && !sep_add;
    wire        need_a    = ieee_seq && den_a;
    wire        need_b    = ieee_seq && den_b;
    wire [33:0] a_now     = norm_op(OPA, FLUSH_ZERO_SELECT);
    wire [33:0] b_now     = norm_op(OPB, FLUSH_ZERO_SELECT);
    wire [33:0] a_late    = norm_op(opa_r, 1'b0);
    wire [33:0] b_late    = norm_op(opb_r, 1'b0);
    wire        res_den   = is_den(FP_RESULT);
    wire        any_nan   = is_nan(OPA) || is_nan(OPB);
    wire        any_snan  = (is_nan(OPA) && !OPA[`DADIO_SP_FRAC_MSB]) ||
                            (is_nan(OPB) && !OPB[`DADIO_SP_FRAC_MSB]);
    // a long source can never feed an operation, nor can a double operand
    wire        long_src  = (!is_float && (SIZE == `DADIO_SIZE_LONG)) ||
                            (is_float && (FLOAT_SIZE == FSZ_DOUBLE));

    dadio_intu u_intu (
        .op       (OPCODE),
        .size     (SIZE),
        .a        (OPA),
        .b        (OPB),
        .lo       (int_lo),
        .mid      (int_mid),
        .long_res (int_long)
    );

    always @* begin
        state_nxt = ST_IDLE;
        case (state_r)
            ST_IDLE: begin
                if (ISSUE && is_float && !long_src) begin
                    if (need_a || need_b)
                        state_nxt = ST_ENTRY;
                    else
                        state_nxt = ST_EXEC;
                end
            end
            ST_ENTRY:
                state_nxt = pend_a_r ? ST_NORM_A : ST_NORM_B;
            ST_NORM_A:
                state_nxt = pend_b_r ? ST_NORM_B : ST_EXEC;
            ST_NORM_B:
                state_nxt = ST_EXEC;
            ST_EXEC: begin
                if (!fz_r && !nan_r && res_den)
                    state_nxt = ST_OUTNORM;
                else
                    state_nxt = ST_IDLE;
            end
            ST_OUTNORM:
                state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // final floating result and the exceptions it raises
    always @* begin
        fin_res  = FP_RESULT;
        flag_set = 5'h00;
        if (state_r == ST_EXEC) begin
            if (nan_r) begin
                fin_res = `DADIO_QNAN;
                flag_set[`DADIO_FLG_INVALID] = snan_r;
            end else begin
                flag_set = FP_EXC;
                if (res_den) begin
                    flag_set[`DADIO_FLG_UNDERFLOW] = 1'b1;
                    if (fz_r)
                        fin_res = {FP_RESULT[`DADIO_SP_SIGN], 31'h00000000};
                end
                if (is_nan(FP_RESULT))
                    fin_res = `DADIO_QNAN;
            end
        end
    end

    always @(posedge CLOCK) begin
        if (!NRST) begin
            state_r    <= ST_IDLE;
            stall_r    <= 1'b0;
            busy_r     <= 1'b0;
            done_r     <= 1'b0;
            long_rej_r <= 1'b0;
            res_low_r  <= 32'h00000000;
            res_mid_r  <= 32'h00000000;
            res_long_r <= 1'b0;
            flags_r    <= `DADIO_FLAGS_RESET;
            fp_go_r    <= 1'b0;
            fp_mul_r   <= 1'b0;
            fz_r       <= 1'b0;
            nan_r      <= 1'b0;
            snan_r     <= 1'b0;
            pend_a_r   <= 1'b0;
            pend_b_r   <= 1'b0;
            opa_r      <= 32'h00000000;
            opb_r      <= 32'h00000000;
            a_exp_r    <= 10'h000;
            a_mant_r   <= 24'h000000;
            b_exp_r    <= 10'h000;
            b_mant_r   <= 24'h000000;
        end else if (CE) begin
            state_r    <= state_nxt;
            stall_r    <= (state_nxt == ST_ENTRY) || (state_nxt == ST_NORM_A) ||
                          (state_nxt == ST_NORM_B) || (state_nxt == ST_OUTNORM);
            busy_r     <= (state_nxt != ST_IDLE);
            fp_go_r    <= (state_nxt == ST_EXEC);
            done_r     <= 1'b0;
            long_rej_r <= 1'b0;
            flags_r    <= (flags_r & ~FLAG_CLEAR) | flag_set;
            case (state_r)
                ST_IDLE: begin
                    if (ISSUE && long_src) begin
                        long_rej_r <= 1'b1;
                    end else if (ISSUE && is_float) begin
                        opa_r    <= OPA;
                        opb_r    <= OPB;
                        fz_r     <= FLUSH_ZERO_SELECT;
                        fp_mul_r <= (OPCODE == `DADIO_OP_FLOAT_MUL);
                        nan_r    <= any_nan;
                        snan_r   <= any_snan;
                        pend_a_r <= need_a;
                        pend_b_r <= need_b;
                        a_exp_r  <= need_a ? 10'h000 : a_now[33:24];
                        a_mant_r <= need_a ? 24'h000000 : a_now[23:0];
                        b_exp_r  <= need_b ? 10'h000 : b_now[33:24];
                        b_mant_r <= need_b ? 24'h000000 : b_now[23:0];
                    end else if (ISSUE) begin
                        res_low_r  <= int_lo;
                        res_mid_r  <= int_mid;
                        res_long_r <= int_long;
                        done_r     <= 1'b1;
                    end
                end
                ST_NORM_A: begin
                    a_exp_r  <= a_late[33:24];
                    a_mant_r <= a_late[23:0];
                    pend_a_r <= 1'b0;
                end
                ST_NORM_B: begin
                    b_exp_r  <= b_late[33:24];
                    b_mant_r <= b_late[23:0];
                    pend_b_r <= 1'b0;
                end
                ST_EXEC: begin
                    res_low_r  <= fin_res;
                    res_mid_r  <= 32'h00000000;
                    res_long_r <= 1'b0;
                    done_r     <= (state_nxt == ST_IDLE);
                end
                ST_OUTNORM: begin
                    done_r <= 1'b1;
                end
                default: begin
                    done_r <= 1'b0;
                end
            endcase
        end
    end

    assign STALL       = stall_r;
    assign BUSY        = busy_r;
    assign DONE        = done_r;
    assign LONG_REJECT = long_rej_r;
    assign RESULT_LOW  = res_low_r;
    assign RESULT_MID  = res_mid_r;
    assign RESULT_LONG = res_long_r;
    assign FLAGS       = flags_r;
    assign FP_GO       = fp_go_r;
    assign FP_MUL      = fp_mul_r;
    assign OPA_SIGN    = opa_r[`DADIO_SP_SIGN];
    assign OPA_EXP     = a_exp_r;
    assign OPA_MANT    = a_mant_r;
    assign OPB_SIGN    = opb_r[`DADIO_SP_SIGN];
    assign OPB_EXP     = b_exp_r;
    assign OPB_MANT    = b_mant_r;
endmodule // dadio_top

// ===== core/dadio_map.vh
// constants of the data alu operand sequencer and integer unit
// included by every design file of the block; definitions only
`ifndef DADIO_MAP_VH
`define DADIO_MAP_VH

// operation codes from the program controller
`define DADIO_OP_ADD                5'h00
`define DADIO_OP_SUB                5'h01
`define DADIO_OP_MUL_SIGNED         5'h02
`define DADIO_OP_MUL_UNSIGNED       5'h03
`define DADIO_OP_AND                5'h04
`define DADIO_OP_AND_COMPLEMENT     5'h05
`define DADIO_OP_OR                 5'h06
`define DADIO_OP_OR_COMPLEMENT      5'h07
`define DADIO_OP_EXCLUSIVE_OR       5'h08
`define DADIO_OP_NOT                5'h09
`define DADIO_OP_ROTATE_RIGHT       5'h0A
`define DADIO_OP_FIELD_DIVIDE_WORD  5'h0B
`define DADIO_OP_FIELD_DIVIDE_BYTE  5'h0C
`define DADIO_OP_FIELD_MERGE_WORD   5'h0D
`define DADIO_OP_FIELD_MERGE_BYTE   5'h0E
`define DADIO_OP_FIELD_EXTRACT_WORD 5'h0F
`define DADIO_OP_FIELD_EXTRACT_BYTE 5'h10
`define DADIO_OP_ARITH_LEFT         5'h11
`define DADIO_OP_ARITH_RIGHT        5'h12
`define DADIO_OP_LOGIC_LEFT         5'h13
`define DADIO_OP_LOGIC_RIGHT        5'h14
`define DADIO_OP_FLOAT_ADD          5'h18
`define DADIO_OP_FLOAT_MUL          5'h19

// integer operand sizes
`define DADIO_SIZE_BYTE             2'h0
`define DADIO_SIZE_SHORT            2'h1
`define DADIO_SIZE_WORD             2'h2
`define DADIO_SIZE_LONG             2'h3
`define DADIO_MASK_BYTE             32'h000000FF
`define DADIO_MASK_SHORT            32'h0000FFFF
`define DADIO_MASK_WORD             32'hFFFFFFFF

// field specifier positions in the second operand
`define DADIO_FLD_OFF_MSB           4
`define DADIO_FLD_OFF_LSB           0
`define DADIO_FLD_WID_MSB           13
`define DADIO_FLD_WID_LSB           8
`define DADIO_FLD_BYTE_WIDTH        6'h08
`define DADIO_FLD_FULL_WIDTH        6'h20

// single precision layout
`define DADIO_SP_SIGN               31
`define DADIO_SP_EXP_MSB            30
`define DADIO_SP_EXP_LSB            23
`define DADIO_SP_FRAC_MSB           22
`define DADIO_SP_EXP_MAX            8'hFF
`define DADIO_SP_EXP_ZERO           8'h00
`define DADIO_QNAN                  32'h7FFFFFFF

// exception flag positions
`define DADIO_FLG_INEXACT           0
`define DADIO_FLG_UNDERFLOW         1
`define DADIO_FLG_OVERFLOW          2
`define DADIO_FLG_DIVZERO           3
`define DADIO_FLG_INVALID           4
`define DADIO_FLAGS_RESET           5'h00

`endif

// ===== core/dadio_intu.v
// integer unit: adder, multiplier, logic unit, bit-field and barrel shifter
// purely combinational; operands are the low portions of the source registers
`timescale 1ns/100ps
`include "dadio_map.vh"

module dadio_intu (
    input  wire [4:0]  op,
    input  wire [1:0]  size,
    input  wire [31:0] a,
    input  wire [31:0] b,
    output reg  [31:0] lo,
    output reg  [31:0] mid,
    output reg         long_res
);
    wire [63:0] prod_s  = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
    wire [63:0] prod_u  = {32'h00000000, a} * {32'h00000000, b};
    wire [4:0]  cnt     = b[`DADIO_FLD_OFF_MSB:`DADIO_FLD_OFF_LSB];
    wire        byte_op = (op == `DADIO_OP_FIELD_DIVIDE_BYTE) ||
                          (op == `DADIO_OP_FIELD_MERGE_BYTE) ||
                          (op == `DADIO_OP_FIELD_EXTRACT_BYTE);
    wire [5:0]  wid     = byte_op ? `DADIO_FLD_BYTE_WIDTH :
                          b[`DADIO_FLD_WID_MSB:`DADIO_FLD_WID_LSB];
    wire [31:0] fmask   = (wid >= `DADIO_FLD_FULL_WIDTH) ? `DADIO_MASK_WORD :
                          ((32'h00000001 << wid) - 32'h00000001);
    wire [31:0] fext    = (a >> cnt) & fmask;
    wire [5:0]  sx      = `DADIO_FLD_FULL_WIDTH - wid;
    wire [31:0] fsext   = $signed(fext << sx) >>> sx;
    reg  [31:0] smask;

    always @* begin
        lo       = 32'h00000000;
        mid      = 32'h00000000;
        long_res = 1'b0;
        case (size)
            `DADIO_SIZE_BYTE:  smask = `DADIO_MASK_BYTE;
            `DADIO_SIZE_SHORT: smask = `DADIO_MASK_SHORT;
            default:           smask = `DADIO_MASK_WORD;
        endcase
        case (op)
            `DADIO_OP_ADD:                lo = (a + b) & smask;
            `DADIO_OP_SUB:                lo = (a - b) & smask;
            `DADIO_OP_MUL_SIGNED: begin
                lo       = prod_s[31:0];
                mid      = prod_s[63:32];
                long_res = 1'b1;
            end
            `DADIO_OP_MUL_UNSIGNED: begin
                lo       = prod_u[31:0];
                mid      = prod_u[63:32];
                long_res = 1'b1;
            end
            `DADIO_OP_AND:                lo = a & b;
            `DADIO_OP_AND_COMPLEMENT:     lo = a & ~b;
            `DADIO_OP_OR:                 lo = a | b;
            `DADIO_OP_OR_COMPLEMENT:      lo = a | ~b;
            `DADIO_OP_EXCLUSIVE_OR:       lo = a ^ b;
            `DADIO_OP_NOT:                lo = ~a;
            `DADIO_OP_ROTATE_RIGHT:       lo = {a[0], a[31:1]};
            `DADIO_OP_FIELD_DIVIDE_WORD,
            `DADIO_OP_FIELD_DIVIDE_BYTE:  lo = fsext;
            `DADIO_OP_FIELD_MERGE_WORD,
            `DADIO_OP_FIELD_MERGE_BYTE:   lo = (a & fmask) << cnt;
            `DADIO_OP_FIELD_EXTRACT_WORD,
            `DADIO_OP_FIELD_EXTRACT_BYTE: lo = fext;
            `DADIO_OP_ARITH_LEFT:         lo = a << cnt;
            `DADIO_OP_ARITH_RIGHT:        lo = $signed(a) >>> cnt;
            `DADIO_OP_LOGIC_LEFT:         lo = a << cnt;
            `DADIO_OP_LOGIC_RIGHT:        lo = a >> cnt;
            default:                      lo = 32'h00000000;
        endcase
    end
endmodule // dadio_intu

// ===== verif/dadio_fpu_model.sv
// float unit stand-in: answers combinationally while fp_go is high
// between answers it shows the inverse, so a stale sample never matches
`timescale 1ns/100ps
module dadio_fpu_model (
    input  wire        fp_go,
    input  wire [31:0] ans,
    input  wire [4:0]  exc,
    output wire [31:0] fp_result,
    output wire [4:0]  fp_exc
);
    assign fp_result = fp_go ? ans : ~ans;
    assign fp_exc    = fp_go ? exc : ~exc;
endmodule // dadio_fpu_model

// ===== verif/dadio_top_monitor.sv
// port checker of the operand sequencer
// bound to dadio_top; cycle counts assume CE stays high
`timescale 1ns/100ps
module dadio_top_monitor (
    input wire        CLOCK,
    input wire        NRST,
    input wire        CE,
    input wire        FLUSH_ZERO_SELECT,
    input wire        ISSUE,
    input wire [4:0]  OPCODE,
    input wire [1:0]  SIZE,
    input wire [1:0]  FLOAT_SIZE,
    input wire        SINGLE_EXTENDED_FORMAT,
    input wire [31:0] OPA,
    input wire [31:0] OPB,
    input wire [31:0] FP_RESULT,
    input wire [4:0]  FLAG_CLEAR,
    input wire        STALL,
    input wire        BUSY,
    input wire        DONE,
    input wire        LONG_REJECT,
    input wire [31:0] RESULT_LOW,
    input wire [4:0]  FLAGS,
    input wire        FP_GO
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    wire tk = ISSUE && CE && !BUSY;
    wire it = tk && OPCODE < 5'h15;
    wire fl = tk && OPCODE[4:1] == 4'hC && FLOAT_SIZE != 2'h1;
    wire sa = SINGLE_EXTENDED_FORMAT && OPCODE == 5'h18;
    wire da = OPA[30:23] == 8'h00 && |OPA[22:0];
    wire db = OPB[30:23] == 8'h00 && |OPB[22:0];
    wire ie = fl && !FLUSH_ZERO_SELECT && !sa;
    reg  [4:0] kept_r;
    // flags that must still be set one edge later
    always @(posedge CLOCK) kept_r <= NRST ? FLAGS & ~FLAG_CLEAR : 5'h00;
    a_int_done: assert property (it && SIZE != 2'h3 |=> DONE && !LONG_REJECT)
        else $error("integer op gave no done");
    a_long_refuse: assert property (it && SIZE == 2'h3 |=> LONG_REJECT && !DONE)
        else $error("long source not refused");
    a_flush_fast: assert property (fl && FLUSH_ZERO_SELECT |=> FP_GO && !STALL)
        else $error("flush mode added cycles");
    a_sep_fast: assert property (fl && sa |=> FP_GO)
        else $error("extended add added cycles");
    a_ieee_one: assert property (ie && (da ^ db) |=> STALL [*2] ##1 (FP_GO && !STALL))
        else $error("one denormal timing wrong");
    a_ieee_two: assert property (ie && da && db |=> STALL [*3] ##1 (FP_GO && !STALL))
        else $error("two denormal timing wrong");
    a_stall_go: assert property (FP_GO |-> !STALL)
        else $error("stall high with operands ready");
    a_flag_sticky: assert property ((FLAGS & kept_r) == kept_r)
        else $error("flag dropped without clear");
    a_nan_out: assert property (FP_GO && &FP_RESULT[30:23] && |FP_RESULT[22:0]
        |=> DONE && RESULT_LOW == 32'h7FFFFFFF)
        else $error("nan result not canonical");
    c_two_denorm: cover property (ie && da && db);
    c_refuse: cover property (LONG_REJECT);
    c_out_norm: cover property (FP_GO ##1 STALL);
endmodule // dadio_top_monitor
bind dadio_top dadio_top_monitor dadio_top_monitor_inst (.*);

// ===== verif/dadio_top_bench.sv
// self-checking bench of the operand sequencer and integer unit
// drives the controller side; the float unit model answers on FP_GO
`timescale 1ns/100ps
module dadio_top_bench;
    logic        CLOCK = 1'h0, NRST = 1'h0, CE = 1'h1, ISSUE = 1'h0;
    logic        FLUSH_ZERO_SELECT = 1'h0, SINGLE_EXTENDED_FORMAT = 1'h0;
    logic [4:0]  OPCODE = 5'h00, FLAG_CLEAR = 5'h00, exc = 5'h00, FP_EXC, FLAGS;
    logic [1:0]  SIZE = 2'h2, FLOAT_SIZE = 2'h0;
    logic [31:0] OPA = 32'h0, OPB = 32'h0, ans = 32'h0, FP_RESULT, RESULT_LOW, RESULT_MID;
    logic        STALL, BUSY, DONE, LONG_REJECT, RESULT_LONG, FP_GO, FP_MUL, OPA_SIGN, OPB_SIGN;
    logic [9:0]  OPA_EXP, OPB_EXP;
    logic [23:0] OPA_MANT, OPB_MANT, ma;
    logic        rej, bz;
    logic [46:0] ob;
    int          errors = 0, checks = 0, cyc = 0, n;
    wire  [64:0] res = {RESULT_LONG, RESULT_MID, RESULT_LOW};
    logic [31:0] lx [17] = '{32'hF000F000, 32'h00F000F0, 32'hFFF0FFF0, 32'hF0FFF0FF,
        32'h0FF00FF0, 32'h0F0F0F0F, 32'h78787878, 32'hFFFFFFF8, 32'hFFFFFFF8, 32'h800,
        32'h800, 32'hF8, 32'hF8, 32'h10, 32'hF8000000, 32'h10, 32'h08000000};
    dadio_top dadio_top_inst (.*);
    dadio_fpu_model dadio_fpu_model_inst (.fp_go(FP_GO), .ans(ans), .exc(exc),
        .fp_result(FP_RESULT), .fp_exc(FP_EXC));
    always #12.5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [65:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one request; n counts edges until done, rej notes a refusal
    task automatic go(input [4:0] op, input [1:0] sz, input fz, single_extended_format,
                      input [31:0] a, b, r, input [4:0] x);
        @(posedge CLOCK);
        ISSUE <= 1'h1;
        OPCODE <= op;
        SIZE <= sz;
        FLOAT_SIZE <= sz;
        FLUSH_ZERO_SELECT <= fz;
        SINGLE_EXTENDED_FORMAT <= single_extended_format;
        OPA <= a;
        OPB <= b;
        ans <= r;
        exc <= x;
        @(posedge CLOCK);
        ISSUE <= 1'h0;
        OPA <= ~a;
        OPB <= ~b;
        n = 1;
        rej = 1'h0;
        bz = 1'h1;
        #1;
        while (DONE !== 1'h1 && n < 9) begin
            rej = rej | (LONG_REJECT === 1'h1);
            bz = bz & (BUSY === 1'h1);
            if (FP_GO === 1'h1) begin
                ma = OPA_MANT;
                ob = {FP_MUL, OPA_SIGN, OPB_SIGN, OPA_EXP, OPB_EXP, OPB_MANT};
            end
            @(posedge CLOCK);
            #1;
            n++;
        end
    endtask
    initial begin
        repeat (2) @(posedge CLOCK);
        NRST <= 1'h1;
        #1;
        chk("reset", {STALL, BUSY, DONE, FLAGS}, 8'h00);
        go(5'h00, 2'h2, 1'h0, 1'h0, 32'hFFFFFFFF, 32'h2, 32'h0, 5'h00);
        chk("add", res, 65'h1);
        go(5'h01, 2'h0, 1'h0, 1'h0, 32'h10, 32'h20, 32'h0, 5'h00);
        chk("sub byte", res, 65'hF0);
        go(5'h00, 2'h1, 1'h0, 1'h0, 32'hFFFF, 32'h1, 32'h0, 5'h00);
        chk("add short", res, 65'h0);
        go(5'h02, 2'h2, 1'h0, 1'h0, 32'hFFFFFFFF, 32'h2, 32'h0, 5'h00);
        chk("mul signed", res, 65'h1FFFFFFFFFFFFFFFE);
        go(5'h03, 2'h2, 1'h0, 1'h0, 32'hFFFFFFFF, 32'h2, 32'h0, 5'h00);
        chk("mul unsigned", res, 65'h100000001FFFFFFFE);
        for (int i = 0; i < 17; i++) begin
            go(5'h04 + i[4:0], 2'h2, 1'h0, 1'h0, i < 7 ? 32'hF0F0F0F0 : i < 13 ? 32'hF80
               : 32'h80000001, i < 7 ? 32'hFF00FF00 : 32'h804, 32'h0, 5'h00);
            chk("logic", res, {33'h0, lx[i]});
        end
        go(5'h00, 2'h3, 1'h0, 1'h0, 32'h5, 32'h5, 32'h0, 5'h00);
        chk("long refuse", {rej, res}, 66'h20000000008000000);
        go(5'h18, 2'h1, 1'h0, 1'h0, 32'h3F800000, 32'h3F800000, 32'h0, 5'h00);
        chk("double refuse", {rej, res}, 66'h20000000008000000);
        $display("test integer done");
        go(5'h18, 2'h0, 1'h1, 1'h0, 32'h1, 32'h3F800000, 32'h3F800000, 5'h00);
        chk("flush time", {n[3:0], ma}, {4'h2, 24'h0});
        go(5'h19, 2'h0, 1'h0, 1'h0, 32'h400000, 32'h3F800000, 32'h3F800000, 5'h00);
        chk("ieee one", {n[3:0], ma, ob[46]}, {4'h4, 24'h800000, 1'h1});
        go(5'h18, 2'h0, 1'h0, 1'h0, 32'h1, 32'h80400000, 32'h3F800000, 5'h00);
        chk("ieee two", {n[3:0], bz, BUSY}, {4'h5, 2'h2});
        chk("operands", ob, {3'h1, 10'h3EA, 10'h000, 24'h800000});
        go(5'h18, 2'h0, 1'h0, 1'h1, 32'h1, 32'h400000, 32'h3F800000, 5'h00);
        chk("extended add", n[3:0], 4'h2);
        go(5'h18, 2'h0, 1'h0, 1'h0, 32'h3F800000, 32'h3F800000, 32'h10, 5'h00);
        chk("out norm", {n[3:0], RESULT_LOW, FLAGS}, {4'h3, 32'h10, 5'h02});
        go(5'h18, 2'h0, 1'h1, 1'h0, 32'h3F800000, 32'h3F800000, 32'h80000010, 5'h00);
        chk("out flush", {n[3:0], RESULT_LOW}, {4'h2, 32'h80000000});
        @(posedge CLOCK);
        FLAG_CLEAR <= 5'h1F;
        @(posedge CLOCK);
        FLAG_CLEAR <= 5'h00;
        #1;
        chk("flag clear", FLAGS, 5'h00);
        go(5'h18, 2'h0, 1'h0, 1'h0, 32'h7FC00000, 32'h3F800000, 32'h7FC00001, 5'h1F);
        chk("quiet nan", {RESULT_LOW, FLAGS}, {32'h7FFFFFFF, 5'h00});
        go(5'h19, 2'h0, 1'h0, 1'h0, 32'h3F800000, 32'h7F800001, 32'h3F800000, 5'h00);
        chk("signal nan", {RESULT_LOW, FLAGS}, {32'h7FFFFFFF, 5'h10});
        go(5'h18, 2'h0, 1'h0, 1'h0, 32'h3F800000, 32'h3F800000, 32'h40000000, 5'h0F);
        chk("all flags", FLAGS, 5'h1F);
        go(5'h18, 2'h0, 1'h0, 1'h0, 32'h3F800000, 32'h3F800000, 32'h40000000, 5'h00);
        chk("flags kept", FLAGS, 5'h1F);
        @(posedge CLOCK);
        CE <= 1'h0;
        FLAG_CLEAR <= 5'h1F;
        @(posedge CLOCK);
        CE <= 1'h1;
        FLAG_CLEAR <= 5'h00;
        #1;
        chk("frozen flags", FLAGS, 5'h1F);
        $display("test float done");
        report_and_stop();
    end
endmodule // dadio_top_bench
